// ### logic/hold_arb_pkg.sv
// Purpose: constants and carriers for the bus hold arbiter and refresh logic
// Assumes: one 50 MHz system clock, active-high asynchronous reset
// Notes: the half-rate clock is an enable pulse, not a second clock
//
// What this block does
// - two hold sources: cascade DMA, timer rise
// - DMA sampled rising, timer falling half-clock phase
// - first captured wins; other waits for completion
// - chain to other source keeping cpu hold request
// - drop hold request only when the other source is not requesting
// - cpu ack then acknowledge DMA controller
// - DMA done: refresh if pending else release
// - refresh wins: request, await ack, strobe low
// - strobe low four edges then release, drop request
// - DMA pending at fourth edge gets acknowledged
// - channel ready low before third edge stretches strobe
// - refresh strobe open drain, external low starts refresh
// - upper address driven only with ack and no master
// - active strobe selects refresh page entry
// - write strobe input re-enables arbiter after int-ack
// - reset clears arbiter state
// - half rate enable from dividing clock by two
// - timer channel one gate always enabled
// - refresh cycle drives refresh page value
package hold_arb_pkg;

   // ***************************************************
   // counts and widths
   // ***************************************************
   localparam int unsigned REFRESH_EDGES = 4;
   localparam int unsigned STRETCH_CHECK_EDGE = 2; // ready sampled before third edge
   localparam int unsigned UPPER_ADDR_W = 7;
   localparam int unsigned PAGE_ENTRIES = 16;
   localparam logic [3:0] REFRESH_PAGE_INDEX = 4'hf;
   localparam logic [2:0] CNT_RESET = 3'h0;

   // ***************************************************
   // states and carriers
   // ***************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_ACK,
      ST_DMA_GRANT,
      ST_REFRESH,
      ST_STRETCH
   } arb_state_e;

   typedef enum logic [1:0] {
      OWNER_NONE,
      OWNER_DMA,
      OWNER_REFRESH
   } owner_e;

   // open-drain pin as three signals
   typedef struct packed {
      logic in_level;
      logic out_level;
      logic out_en;
   } od_pin_s;

   // page mapper write port
   typedef struct packed {
      logic we;
      logic [3:0] index;
      logic [UPPER_ADDR_W-1:0] data;
   } page_wr_s;

endpackage

// ### logic/level_sync.sv
// Purpose: two-flop synchroniser for one level
// Assumes: single system clock
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module level_sync #(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_level,
   output logic o_level
);
   typedef struct packed {
      logic stage1;
      logic stage2;
   } sync_s;

   sync_s state;
   sync_s next_state;

   // shift the level through two flops
   always_comb begin
      next_state.stage1 = i_level;
      next_state.stage2 = state.stage1;
   end

   // asynchronous reset to a constant only
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= {RESET_VALUE, RESET_VALUE};
      end else begin
         state <= next_state;
      end
   end

   assign o_level = state.stage2;
endmodule

// ### logic/hold_arbiter_refresh.sv
// Purpose: arbitrate cascade DMA and refresh hold requests toward the CPU
// Assumes: all inputs synchronous to i_sys_clk except the refresh pin input
// Notes: the far side keeps hold ack up until the hold request drops
`timescale 1ns/1ps
module hold_arbiter_refresh #(
   parameter int unsigned ADDR_W = hold_arb_pkg::UPPER_ADDR_W
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_dma_hold_request,
   input wire logic i_timer1_out,
   input wire logic i_cpu_hold_ack,
   input wire logic i_channel_ready,
   input wire logic i_external_master_n,
   input wire logic i_refresh_pin_in,
   input wire logic i_mem_write_strobe_in_n,
   input wire logic i_int_ack_active,
   input wire logic i_dma_cycle_active,
   input wire logic i_dma_mem_write_n,
   input wire logic [3:0] i_dma_page_index,
   input wire hold_arb_pkg::page_wr_s i_page_wr,
   output logic o_timer1_gate,
   output logic o_half_rate_enable,
   output logic o_cpu_hold_request,
   output logic o_dma_hold_ack,
   output logic o_refresh_pin_low,
   output logic o_refresh_pin_oe,
   output logic o_mem_write_strobe_out_n,
   output logic o_mem_write_strobe_oe,
   output logic [ADDR_W-1:0] o_upper_address_bits,
   output logic o_upper_address_oe
);

   // ***************************************************
   // state record
   // ***************************************************
   typedef struct packed {
      hold_arb_pkg::arb_state_e fsm;
      hold_arb_pkg::owner_e owner;
      logic half_phase;
      logic dma_seen;
      logic refresh_pending;
      logic timer_prev;
      logic ext_prev;
      logic [2:0] edge_cnt;
      logic strobe_drive;
      logic dma_ack;
      logic hold_req;
      logic int_ack_lock;
      logic [ADDR_W-1:0] upper_addr;
   } arb_s;

   arb_s state;
   arb_s next_state;
   logic ext_low_sync;
   logic [ADDR_W-1:0] page_mem [hold_arb_pkg::PAGE_ENTRIES];
   logic timer_rise;
   logic ext_fall;
   logic dma_req_live;
   logic dma_sample_en;
   logic refresh_sample_en;

   // ***************************************************
   // input conditioning
   // ***************************************************

   // pin low seen from outside, only when we are not driving it
   level_sync #(
      .RESET_VALUE(1'b0)
   ) u_ext_refresh_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_level(~i_refresh_pin_in & ~state.strobe_drive),
      .o_level(ext_low_sync)
   );

   // counter one runs continuously, gate tied high
   assign o_timer1_gate = 1'b1;

   // half rate enable: rising phase on one cycle, falling on the next
   assign o_half_rate_enable = ~state.half_phase;
   assign dma_sample_en = ~state.half_phase;
   assign refresh_sample_en = state.half_phase;

   assign timer_rise = i_timer1_out & ~state.timer_prev;
   assign ext_fall = ext_low_sync & ~state.ext_prev;
   assign dma_req_live = i_dma_hold_request & ~state.int_ack_lock;

   // ***************************************************
   // page mapper store
   // ***************************************************

   // page entries written by the mapper port; not reset, software loads them
   always_ff @(posedge i_sys_clk) begin
      if (i_page_wr.we) begin
         page_mem[i_page_wr.index] <= i_page_wr.data;
      end
   end

   // ***************************************************
   // arbiter next state
   // ***************************************************
   always_comb begin
      next_state = state;
      next_state.half_phase = ~state.half_phase;
      next_state.timer_prev = i_timer1_out;
      next_state.ext_prev = ext_low_sync;

      // interrupt acknowledge locks arbiter until write strobe input pulses
      if (i_int_ack_active) begin
         next_state.int_ack_lock = 1'b1;
      end else if (!i_dma_cycle_active && !i_mem_write_strobe_in_n) begin
         next_state.int_ack_lock = 1'b0;
      end

      // set wins over clear: a rise during a refresh queues the next one
      if (timer_rise || ext_fall) begin
         next_state.refresh_pending = 1'b1;
      end

      // phase sampling of the DMA request
      if (dma_sample_en) begin
         next_state.dma_seen = dma_req_live;
      end

      case (state.fsm)
         hold_arb_pkg::ST_IDLE: begin
            // first captured wins; the other simply stays latched
            if (dma_sample_en && dma_req_live) begin
               next_state.owner = hold_arb_pkg::OWNER_DMA;
               next_state.hold_req = 1'b1;
               next_state.fsm = hold_arb_pkg::ST_WAIT_ACK;
            end else if (refresh_sample_en && state.refresh_pending
                  && !state.int_ack_lock) begin
               next_state.owner = hold_arb_pkg::OWNER_REFRESH;
               next_state.hold_req = 1'b1;
               next_state.fsm = hold_arb_pkg::ST_WAIT_ACK;
            end
         end
         hold_arb_pkg::ST_WAIT_ACK: begin
            if (i_cpu_hold_ack) begin
               if (state.owner == hold_arb_pkg::OWNER_DMA) begin
                  next_state.dma_ack = 1'b1;
                  next_state.fsm = hold_arb_pkg::ST_DMA_GRANT;
               end else begin
                  next_state.strobe_drive = 1'b1;
                  next_state.refresh_pending = timer_rise | ext_fall;
                  next_state.edge_cnt = hold_arb_pkg::CNT_RESET;
                  next_state.fsm = hold_arb_pkg::ST_REFRESH;
               end
            end
         end
         hold_arb_pkg::ST_DMA_GRANT: begin
            if (!i_dma_hold_request) begin
               next_state.dma_ack = 1'b0;
               if (state.refresh_pending) begin
                  next_state.owner = hold_arb_pkg::OWNER_REFRESH;
                  next_state.strobe_drive = 1'b1;
                  next_state.refresh_pending = timer_rise | ext_fall;
                  next_state.edge_cnt = hold_arb_pkg::CNT_RESET;
                  next_state.fsm = hold_arb_pkg::ST_REFRESH;
               end else begin
                  next_state.hold_req = 1'b0;
                  next_state.owner = hold_arb_pkg::OWNER_NONE;
                  next_state.fsm = hold_arb_pkg::ST_IDLE;
               end
            end
         end
         hold_arb_pkg::ST_REFRESH: begin
            next_state.edge_cnt = state.edge_cnt + 3'h1;
            // not-ready before the third edge holds the strobe low
            if (state.edge_cnt == 3'(hold_arb_pkg::STRETCH_CHECK_EDGE)
                  && !i_channel_ready) begin
               next_state.fsm = hold_arb_pkg::ST_STRETCH;
            end else if (state.edge_cnt == 3'(hold_arb_pkg::REFRESH_EDGES - 1)) begin
               next_state.strobe_drive = 1'b0;
               if (i_dma_hold_request && !state.int_ack_lock) begin
                  next_state.owner = hold_arb_pkg::OWNER_DMA;
                  next_state.dma_ack = 1'b1;
                  next_state.fsm = hold_arb_pkg::ST_DMA_GRANT;
               end else begin
                  next_state.hold_req = 1'b0;
                  next_state.owner = hold_arb_pkg::OWNER_NONE;
                  next_state.fsm = hold_arb_pkg::ST_IDLE;
               end
            end
         end
         hold_arb_pkg::ST_STRETCH: begin
            // resume the count at the fourth edge once ready returns
            if (i_channel_ready) begin
               next_state.edge_cnt = 3'(hold_arb_pkg::REFRESH_EDGES - 1);
               next_state.fsm = hold_arb_pkg::ST_REFRESH;
            end
         end
         default: begin
            next_state.fsm = hold_arb_pkg::ST_IDLE;
         end
      endcase

      // refresh entry chosen from the next strobe, so the first low cycle is covered
      if (next_state.strobe_drive || ext_low_sync) begin
         next_state.upper_addr = page_mem[hold_arb_pkg::REFRESH_PAGE_INDEX];
      end else begin
         next_state.upper_addr = page_mem[i_dma_page_index];
      end
   end

   // ***************************************************
   // state register
   // ***************************************************

   // reset clears every arbiter flag
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign o_cpu_hold_request = state.hold_req;
   assign o_dma_hold_ack = state.dma_ack;

   // open drain: level always low, enable while pulling
   assign o_refresh_pin_low = 1'b0;
   assign o_refresh_pin_oe = state.strobe_drive;

   // write strobe driven only during DMA cycles, otherwise an input
   assign o_mem_write_strobe_out_n = i_dma_mem_write_n;
   assign o_mem_write_strobe_oe = i_dma_cycle_active;

   // upper bits float whenever the cpu owns the bus or a master is present
   assign o_upper_address_bits = state.upper_addr;
   assign o_upper_address_oe = i_cpu_hold_ack & i_external_master_n;

endmodule

// ### test/cpu_hold_model.sv
// Purpose: CPU side of the bus hold handshake
// Assumes: system clock only, reset active high
// Notes: ack delay is a parameter; the test uses one CPU with a delay of 2
`timescale 1ns/1ps
module cpu_hold_model #(
   parameter int DELAY = 2
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_cpu_hold_request,
   output logic o_cpu_hold_ack
);
   int cnt;
   // ack only after the bus is free, dropped as soon as request goes
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 0;
         o_cpu_hold_ack <= 1'b0;
      end else begin
         cnt <= i_cpu_hold_request ? cnt + 1 : 0;
         o_cpu_hold_ack <= i_cpu_hold_request && (cnt >= DELAY);
      end
   end
endmodule

// ### test/hold_arbiter_refresh_chk.sv
// Purpose: port level checks of the hold arbiter
// Assumes: one clock domain
// Notes: bound to every instance of the arbiter
`timescale 1ns/1ps
module hold_arbiter_refresh_chk (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_cpu_hold_ack,
   input wire logic i_channel_ready,
   input wire logic i_external_master_n,
   input wire logic i_dma_cycle_active,
   input wire logic o_timer1_gate,
   input wire logic o_half_rate_enable,
   input wire logic o_cpu_hold_request,
   input wire logic o_dma_hold_ack,
   input wire logic o_refresh_pin_oe,
   input wire logic o_mem_write_strobe_oe,
   input wire logic o_upper_address_oe
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // grant and strobe relations
   a_gate_always: assert property (o_timer1_gate == 1'b1)
      else $error("timer gate low");
   a_addr_drive: assert property (o_upper_address_oe == (i_cpu_hold_ack && i_external_master_n))
      else $error("upper address enable wrong");
   a_dma_ack_cause: assert property ($rose(o_dma_hold_ack) |-> $past(i_cpu_hold_ack) && o_cpu_hold_request)
      else $error("dma ack without cpu ack");
   a_strobe_after_ack: assert property ($rose(o_refresh_pin_oe) |-> $past(i_cpu_hold_ack))
      else $error("strobe without cpu ack");
   a_strobe_needs_hold: assert property (o_refresh_pin_oe |-> o_cpu_hold_request)
      else $error("strobe without hold request");
   a_strobe_length: assert property ($rose(o_refresh_pin_oe) |-> o_refresh_pin_oe[*4])
      else $error("strobe shorter than four edges");
   a_single_grant: assert property (!(o_dma_hold_ack && o_refresh_pin_oe))
      else $error("both sources granted");
   a_release_clean: assert property ($fell(o_cpu_hold_request) |-> !o_refresh_pin_oe)
      else $error("hold dropped during refresh");
   a_stretch_hold: assert property (o_refresh_pin_oe && !i_channel_ready |=> o_refresh_pin_oe)
      else $error("strobe released while not ready");
   a_half_toggle: assert property (o_half_rate_enable |=> !o_half_rate_enable)
      else $error("half rate enable not alternating");
   a_strobe_dir: assert property (o_mem_write_strobe_oe == i_dma_cycle_active)
      else $error("write strobe direction wrong");
   c_dma: cover property ($rose(o_dma_hold_ack));
   c_refresh: cover property ($rose(o_refresh_pin_oe));
   c_stretch: cover property (o_refresh_pin_oe && !i_channel_ready);
endmodule
bind hold_arbiter_refresh hold_arbiter_refresh_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
   .i_cpu_hold_ack(i_cpu_hold_ack), .i_channel_ready(i_channel_ready),
   .i_external_master_n(i_external_master_n), .i_dma_cycle_active(i_dma_cycle_active),
   .o_timer1_gate(o_timer1_gate), .o_half_rate_enable(o_half_rate_enable),
   .o_cpu_hold_request(o_cpu_hold_request), .o_dma_hold_ack(o_dma_hold_ack),
   .o_refresh_pin_oe(o_refresh_pin_oe), .o_mem_write_strobe_oe(o_mem_write_strobe_oe),
   .o_upper_address_oe(o_upper_address_oe));

// ### test/hold_arbiter_refresh_test.sv
// Purpose: directed scenarios for the hold arbiter
// Assumes: 50 MHz clock, inputs driven on rising edge, outputs read on falling
// Notes: refresh pin level is worked out here from both pull-down sources
`timescale 1ns/1ps
module hold_arbiter_refresh_test;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic dma_req = 1'b0;
   logic timer = 1'b0;
   logic ready = 1'b1;
   logic master_n = 1'b1;
   logic ext_low = 1'b0;
   logic int_ack = 1'b0;
   logic ws_in_n = 1'b1;
   logic dma_cyc = 1'b0;
   logic dma_wr_n = 1'b1;
   hold_arb_pkg::page_wr_s page_wr = '0;
   logic ack, gate, half, hreq, dack, pin_low, pin_oe, ws_n, ws_oe, addr_oe;
   logic [6:0] addr;
   int err_count = 0;
   int n_tests = 0;
   always #10 i_sys_clk = ~i_sys_clk;
   // pulled-up wire, low when either party pulls
   hold_arbiter_refresh u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_dma_hold_request(dma_req),
      .i_timer1_out(timer), .i_cpu_hold_ack(ack), .i_channel_ready(ready),
      .i_external_master_n(master_n), .i_refresh_pin_in(!(pin_oe | ext_low)),
      .i_mem_write_strobe_in_n(ws_in_n), .i_int_ack_active(int_ack), .i_dma_cycle_active(dma_cyc),
      .i_dma_mem_write_n(dma_wr_n), .i_dma_page_index(4'h0), .i_page_wr(page_wr),
      .o_timer1_gate(gate), .o_half_rate_enable(half), .o_cpu_hold_request(hreq),
      .o_dma_hold_ack(dack), .o_refresh_pin_low(pin_low), .o_refresh_pin_oe(pin_oe),
      .o_mem_write_strobe_out_n(ws_n), .o_mem_write_strobe_oe(ws_oe),
      .o_upper_address_bits(addr), .o_upper_address_oe(addr_oe));
   cpu_hold_model #(.DELAY(2)) u_cpu (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_cpu_hold_request(hreq), .o_cpu_hold_ack(ack));
   task automatic print_verdict;
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // bounded wait on hold request, dma ack or strobe
   task automatic wait_on(input int sel, input logic v);
      logic s;
      for (int i = 0; i < 200; i++) begin
         @(negedge i_sys_clk);
         s = (sel == 0) ? hreq : (sel == 1) ? dack : pin_oe;
         if (s === v) return;
      end
      chk(8'hee, 8'h00);
   endtask
   task automatic t_dma;
      @(posedge i_sys_clk) dma_req <= 1'b1;
      wait_on(1, 1'b1);
      chk({hreq, pin_oe, addr_oe}, 8'h05);
      @(posedge i_sys_clk) master_n <= 1'b0;
      @(negedge i_sys_clk);
      chk(addr_oe, 8'h00);
      @(posedge i_sys_clk) begin
         master_n <= 1'b1;
         dma_req <= 1'b0;
      end
      wait_on(0, 1'b0);
      chk({dack, pin_oe}, 8'h00);
   endtask
   // refresh from timer or pin, optionally stretched by ready
   task automatic t_refresh(input logic [6:0] pg, input int stall, input logic ext);
      int n;
      @(posedge i_sys_clk) begin
         page_wr <= '{we: 1'b1, index: 4'hf, data: pg};
         timer <= !ext;
         ext_low <= ext;
         ready <= (stall == 0);
      end
      @(posedge i_sys_clk) begin
         page_wr.we <= 1'b0;
         timer <= 1'b0;
         ext_low <= 1'b0;
      end
      wait_on(2, 1'b1);
      chk({hreq, addr}, {1'b1, pg});
      n = 0;
      while (pin_oe === 1'b1 && n < 100) begin
         n++;
         @(posedge i_sys_clk);
         if (n == stall) ready <= 1'b1;
         @(negedge i_sys_clk);
      end
      if (stall == 0) chk(n[7:0], 8'h04);
      else chk(n[7:0], 8'(stall + 2));
      chk(hreq, 8'h00);
   endtask
   // dma grant with refresh queued behind it, then dma queued behind refresh
   task automatic t_chain;
      @(posedge i_sys_clk) dma_req <= 1'b1;
      wait_on(1, 1'b1);
      @(posedge i_sys_clk) timer <= 1'b1;
      @(posedge i_sys_clk) timer <= 1'b0;
      repeat (4) @(negedge i_sys_clk);
      chk(pin_oe, 8'h00);
      @(posedge i_sys_clk) dma_req <= 1'b0;
      wait_on(2, 1'b1);
      chk(hreq, 8'h01);
      @(posedge i_sys_clk) dma_req <= 1'b1;
      wait_on(1, 1'b1);
      chk({hreq, pin_oe}, 8'h02);
      @(posedge i_sys_clk) dma_req <= 1'b0;
      wait_on(0, 1'b0);
   endtask
   // interrupt ack locks out new holds until the write strobe input pulses
   task automatic t_lock;
      @(posedge i_sys_clk) begin
         int_ack <= 1'b1;
         dma_cyc <= 1'b1;
         dma_wr_n <= 1'b0;
      end
      @(negedge i_sys_clk);
      chk({ws_oe, ws_n}, 8'h02);
      @(posedge i_sys_clk) begin
         int_ack <= 1'b0;
         dma_cyc <= 1'b0;
         dma_wr_n <= 1'b1;
         dma_req <= 1'b1;
      end
      repeat (8) @(negedge i_sys_clk);
      chk({hreq, ws_oe}, 8'h00);
      @(posedge i_sys_clk) ws_in_n <= 1'b0;
      @(posedge i_sys_clk) ws_in_n <= 1'b1;
      wait_on(1, 1'b1);
      chk(hreq, 8'h01);
      @(posedge i_sys_clk) dma_req <= 1'b0;
      wait_on(0, 1'b0);
   endtask
   initial begin
      repeat (20) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      @(negedge i_sys_clk);
      chk({gate, pin_low, hreq, dack, pin_oe}, 8'h10);
      t_dma();
      t_refresh(7'h5a, 0, 1'b0);
      t_refresh(7'h33, 7, 1'b0);
      t_refresh(7'h21, 0, 1'b1);
      t_chain();
      t_lock();
      print_verdict();
   end
   // watchdog well beyond the few hundred cycles the scenarios need
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
endmodule
